// >>> common/scsiin_pkg.sv
// scsi initiator package: bus pin groups, phase codes and timing constants
// assumes a single 100 mhz system clock
package scsiin_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned RST_PULSE_NS  = 800;
  // least time rounds up to whole cycles
  localparam int unsigned RST_PULSE_CYC =
    (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ARB_DELAY_NS  = 2400;
  localparam int unsigned ARB_DELAY_CYC =
    (ARB_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SEL_TMO_CYC   = 25000;
  // own busy release drains through the input synchroniser
  localparam int unsigned BSY_SETTLE_CYC = 8;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned ID_W          = 3;

  // phase code {msg, cd, io}
  localparam logic [2:0] PH_DATA_OUT = 3'h0;
  localparam logic [2:0] PH_DATA_IN  = 3'h1;
  localparam logic [2:0] PH_COMMAND  = 3'h2;
  localparam logic [2:0] PH_STATUS   = 3'h3;
  localparam logic [2:0] PH_MSG_OUT  = 3'h6;
  localparam logic [2:0] PH_MSG_IN   = 3'h7;
  localparam int unsigned PH_IO_BIT  = 0;

  // control lines sensed on the bus, asserted high inside the logic
  typedef struct packed {
    logic bsy;
    logic sel;
    logic msg;
    logic cd;
    logic io;
    logic req;
    logic rst;
  } scsiin_bus_in_t;

  // data bus and parity byte
  typedef struct packed {
    logic       par;
    logic [7:0] data;
  } scsiin_byte_t;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_WAITFREE = 4'h1,
    ST_ARB      = 4'h2,
    ST_SEL      = 4'h3,
    ST_SELWAIT  = 4'h4,
    ST_XFER     = 4'h5,
    ST_ACKHOLD  = 4'h6,
    ST_RELEASE  = 4'h7,
    ST_BUSRST   = 4'h8
  } scsiin_state_t;

endpackage

// >>> src/scsiin_ctrl.sv
// scsi initiator controller: arbitrates, selects a target and moves bytes
// assumes bus pins are converted to active-high logic and resolved outside
module scsiin_ctrl #(
  parameter int unsigned       SEL_TMO  = scsiin_pkg::SEL_TMO_CYC,
  parameter logic [2:0]        OWN_ID   = 3'h7,
  parameter bit                SKIP_ARB = 1'b0
) (
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_reset,
  // user side
  input  wire logic                     i_start,
  input  wire logic [2:0]               i_target_id,
  input  wire logic                     i_atn,
  input  wire logic                     i_bus_reset,
  input  wire logic                     i_release,
  input  wire logic [7:0]               i_tx_data,
  output logic                          o_tx_ready,
  output logic [7:0]                    o_rx_data,
  output logic                          o_rx_valid,
  output logic [2:0]                    o_phase,
  output logic                          o_connected,
  output logic                          o_busy,
  output logic                          o_sel_timeout,
  output logic                          o_arb_lost,
  output logic                          o_parity_err,
  // bus side, active high, three signals per two-way pin except rst, which is sensed and driven with no enable
  input  wire scsiin_pkg::scsiin_bus_in_t i_bus,
  input  wire scsiin_pkg::scsiin_byte_t   i_db,
  output scsiin_pkg::scsiin_byte_t        o_db,
  output logic                          o_db_oe_n,
  output logic                          o_bsy,
  output logic                          o_bsy_oe_n,
  output logic                          o_sel,
  output logic                          o_sel_oe_n,
  output logic                          o_ack,
  output logic                          o_atn,
  output logic                          o_rst
);

  // ==========================================================
  // input synchronisers
  localparam int unsigned NIN = $bits(scsiin_pkg::scsiin_bus_in_t) + 9;
  logic [NIN-1:0] raw, s1_r, s2_r, s3_r, flt_r;
  assign raw = {i_bus, i_db};
  genvar g;
  generate
    for (g = 0; g < NIN; g++) begin : g_sync
      always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
          s1_r[g]  <= 1'b0;
          s2_r[g]  <= 1'b0;
          s3_r[g]  <= 1'b0;
          flt_r[g] <= 1'b0;
        end else begin
          s1_r[g] <= raw[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          if (s2_r[g] == s3_r[g]) begin
            flt_r[g] <= s3_r[g];
          end
        end
      end
    end
  endgenerate

  scsiin_pkg::scsiin_bus_in_t bus;
  scsiin_pkg::scsiin_byte_t   db;
  assign {bus, db} = flt_r;

  logic bus_free;
  assign bus_free = !bus.bsy && !bus.sel;
  logic [2:0] ph;
  assign ph = {bus.msg, bus.cd, bus.io};
  logic to_init;
  assign to_init = ph[scsiin_pkg::PH_IO_BIT];

  // ==========================================================
  // state machine
  scsiin_pkg::scsiin_state_t st_r;
  logic [15:0] cnt_r;
  logic [7:0]  idmask;
  assign idmask = 8'h01 << OWN_ID;
  logic [2:0]  tgt_r;

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      st_r  <= scsiin_pkg::ST_IDLE;
      cnt_r <= 16'h0000;
      tgt_r <= 3'h0;
    end else begin
      case (st_r)
        scsiin_pkg::ST_IDLE: begin
          cnt_r <= 16'h0000;
          if (i_bus_reset) begin
            st_r <= scsiin_pkg::ST_BUSRST;
          end else if (i_start) begin
            tgt_r <= i_target_id;
            st_r  <= scsiin_pkg::ST_WAITFREE;
          end
        end
        scsiin_pkg::ST_WAITFREE: begin
          // others holding busy keep us out
          if (bus_free) begin
            cnt_r <= 16'h0000;
            st_r  <= SKIP_ARB ? scsiin_pkg::ST_SEL : scsiin_pkg::ST_ARB;
          end
        end
        scsiin_pkg::ST_ARB: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r >= 16'(scsiin_pkg::ARB_DELAY_CYC)) begin
            cnt_r <= 16'h0000;
            // highest id on the bus wins
            if ((db.data & ~((idmask << 1) - 8'h01)) == 8'h00 && !bus.sel) begin
              st_r <= scsiin_pkg::ST_SEL;
            end else begin
              st_r <= scsiin_pkg::ST_WAITFREE;
            end
          end
        end
        scsiin_pkg::ST_SEL: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r >= 16'h0004) begin
            cnt_r <= 16'h0000;
            st_r  <= scsiin_pkg::ST_SELWAIT;
          end
        end
        scsiin_pkg::ST_SELWAIT: begin
          cnt_r <= cnt_r + 16'h0001;
          // our own busy is still in the synchroniser for a few cycles
          if (bus.bsy && cnt_r >= 16'(scsiin_pkg::BSY_SETTLE_CYC)) begin
            st_r <= scsiin_pkg::ST_XFER;
          end else if (cnt_r >= 16'(SEL_TMO)) begin
            st_r <= scsiin_pkg::ST_IDLE;
          end
        end
        scsiin_pkg::ST_XFER: begin
          if (i_bus_reset) begin
            cnt_r <= 16'h0000;
            st_r  <= scsiin_pkg::ST_BUSRST;
          end else if (!bus.bsy) begin
            st_r <= scsiin_pkg::ST_IDLE;
          end else if (bus.req && (to_init || !i_release)) begin
            st_r <= scsiin_pkg::ST_ACKHOLD;
          end else if (i_release && !bus.req) begin
            st_r <= scsiin_pkg::ST_RELEASE;
          end
        end
        scsiin_pkg::ST_ACKHOLD: begin
          if (!bus.req) begin
            st_r <= scsiin_pkg::ST_XFER;
          end
        end
        scsiin_pkg::ST_RELEASE: begin
          if (!bus.bsy) begin
            st_r <= scsiin_pkg::ST_IDLE;
          end
        end
        scsiin_pkg::ST_BUSRST: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r >= 16'(scsiin_pkg::RST_PULSE_CYC)) begin
            st_r <= scsiin_pkg::ST_IDLE;
          end
        end
        default: st_r <= scsiin_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // bus drivers
  logic [7:0] odata;
  logic       ddrv;
  always_comb begin
    odata = 8'h00;
    ddrv  = 1'b0;
    case (st_r)
      scsiin_pkg::ST_ARB: begin
        odata = idmask;
        ddrv  = 1'b1;
      end
      scsiin_pkg::ST_SEL, scsiin_pkg::ST_SELWAIT: begin
        odata = idmask | (8'h01 << tgt_r);
        ddrv  = 1'b1;
      end
      scsiin_pkg::ST_XFER: begin
        // drive only once req is seen, so a turned bus never collides
        odata = i_tx_data;
        ddrv  = !to_init && bus.req;
      end
      scsiin_pkg::ST_ACKHOLD: begin
        odata = i_tx_data;
        ddrv  = !to_init;
      end
      default: begin
        odata = 8'h00;
        ddrv  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_db      <= '0;
      o_db_oe_n <= 1'b1;
      o_bsy     <= 1'b0;
      o_bsy_oe_n <= 1'b1;
      o_sel     <= 1'b0;
      o_sel_oe_n <= 1'b1;
      o_ack     <= 1'b0;
      o_atn     <= 1'b0;
      o_rst     <= 1'b0;
    end else begin
      o_db.data <= odata;
      o_db.par  <= ~^odata;
      o_db_oe_n <= !ddrv;
      // busy in arbitration and selection, released for target reply
      o_bsy      <= (st_r == scsiin_pkg::ST_ARB) || (st_r == scsiin_pkg::ST_SEL);
      o_bsy_oe_n <= !((st_r == scsiin_pkg::ST_ARB) || (st_r == scsiin_pkg::ST_SEL));
      o_sel      <= (st_r == scsiin_pkg::ST_SEL) || (st_r == scsiin_pkg::ST_SELWAIT);
      o_sel_oe_n <= !((st_r == scsiin_pkg::ST_SEL) || (st_r == scsiin_pkg::ST_SELWAIT));
      o_ack      <= (st_r == scsiin_pkg::ST_ACKHOLD) && bus.req;
      o_atn      <= i_atn && (st_r != scsiin_pkg::ST_IDLE);
      o_rst      <= (st_r == scsiin_pkg::ST_BUSRST);
    end
  end

  // ==========================================================
  // user side status
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_rx_data     <= 8'h00;
      o_rx_valid    <= 1'b0;
      o_parity_err  <= 1'b0;
      o_sel_timeout <= 1'b0;
      o_arb_lost    <= 1'b0;
      o_phase       <= 3'h0;
    end else begin
      o_rx_valid    <= 1'b0;
      o_parity_err  <= 1'b0;
      o_phase       <= ph;
      o_sel_timeout <= (st_r == scsiin_pkg::ST_SELWAIT) && !bus.bsy &&
                       (cnt_r >= 16'(SEL_TMO));
      o_arb_lost    <= (st_r == scsiin_pkg::ST_ARB) &&
                       (cnt_r >= 16'(scsiin_pkg::ARB_DELAY_CYC)) &&
                       !((db.data & ~((idmask << 1) - 8'h01)) == 8'h00 && !bus.sel);
      if (st_r == scsiin_pkg::ST_XFER && bus.req && to_init) begin
        o_rx_data    <= db.data;
        o_rx_valid   <= 1'b1;
        o_parity_err <= ~^{db.par, db.data};
      end
    end
  end

  assign o_tx_ready  = (st_r == scsiin_pkg::ST_XFER) && bus.req && !to_init;
  assign o_connected = (st_r == scsiin_pkg::ST_XFER) || (st_r == scsiin_pkg::ST_ACKHOLD);
  assign o_busy      = (st_r != scsiin_pkg::ST_IDLE) || !bus_free;
  // rely on the target; phase code is reported as seen
  // bus reset from another party is not acted on
  logic unused_ok;
  assign unused_ok = bus.rst;

endmodule

// >>> verification/scsiin_ctrl_properties.sv
// checker for the initiator controller, watching its ports only
// assumes a single clock domain and arbitration enabled
module scsiin_ctrl_chk #(
  parameter logic [2:0] OWN_ID = 3'h7
) (
  input wire logic                     i_clk_sys,
  input wire logic                     i_reset,
  input wire logic                     i_atn,
  input wire scsiin_pkg::scsiin_bus_in_t i_bus,
  input wire scsiin_pkg::scsiin_byte_t   o_db,
  input wire logic                     o_db_oe_n,
  input wire logic                     o_bsy,
  input wire logic                     o_bsy_oe_n,
  input wire logic                     o_sel,
  input wire logic                     o_sel_oe_n,
  input wire logic                     o_ack,
  input wire logic                     o_atn,
  input wire logic                     o_rst,
  input wire logic                     o_connected
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  logic        drv_bsy;
  logic        drv_sel;
  int unsigned rst_len_r;
  assign drv_bsy = !o_bsy_oe_n && o_bsy;
  assign drv_sel = !o_sel_oe_n && o_sel;
  // length of the current bus reset pulse
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) rst_len_r <= 0;
    else rst_len_r <= o_rst ? rst_len_r + 1 : 0;
  end
  // ==========================================
  // properties
  a_reset_idle: assert property ($fell(i_reset) |-> o_bsy_oe_n && o_sel_oe_n && o_db_oe_n)
    else $error("pins driven right after reset");
  a_free_before_arb: assert property ($rose(drv_bsy) && o_sel_oe_n |->
    $past(!i_bus.bsy && !i_bus.sel))
    else $error("arbitration began on a busy bus");
  a_arb_own_id: assert property (drv_bsy && !drv_sel && !o_db_oe_n |->
    o_db.data == (8'h01 << OWN_ID))
    else $error("arbitration data is not the own id bit");
  a_db_odd_parity: assert property (!o_db_oe_n && !drv_bsy |-> ^o_db == 1'b1)
    else $error("driven byte without odd parity");
  a_sel_after_arb: assert property ($rose(drv_sel) |-> $past(drv_bsy))
    else $error("select raised without holding busy");
  a_ack_on_req: assert property ($rose(o_ack) |-> i_bus.req)
    else $error("ack raised without req");
  a_ack_holds: assert property (o_ack && i_bus.req |=> o_ack)
    else $error("ack dropped while req high");
  a_ack_drops: assert property ($fell(i_bus.req) |-> ##[1:8] !o_ack)
    else $error("ack not released after req fell");
  a_rst_width: assert property ($fell(o_rst) |-> rst_len_r >= scsiin_pkg::RST_PULSE_CYC)
    else $error("bus reset pulse too short");
  a_atn_follow: assert property ($rose(i_atn) && o_connected |-> ##[1:3] o_atn)
    else $error("attention not driven");
endmodule

bind scsiin_ctrl scsiin_ctrl_chk #(.OWN_ID(OWN_ID)) u_chk (.i_clk_sys, .i_reset, .i_atn, .i_bus,
  .o_db, .o_db_oe_n, .o_bsy, .o_bsy_oe_n, .o_sel, .o_sel_oe_n, .o_ack, .o_atn, .o_rst, .o_connected);

// >>> verification/scsiin_tgt_model.sv
// target device model: answers selection and runs req/ack byte transfers
// assumes active-high bus lines resolved by the bench, negated when released
module scsiin_tgt_model #(
  parameter logic [2:0] TGT_ID = 3'h3
) (
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_reset,
  input  wire logic                     i_bsy,
  input  wire logic                     i_sel,
  input  wire logic                     i_ack,
  input  wire logic                     i_rst,
  input  wire scsiin_pkg::scsiin_byte_t i_db,
  output scsiin_pkg::scsiin_bus_in_t    o_lines,
  output scsiin_pkg::scsiin_byte_t      o_db,
  output logic                          o_db_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  int rst_cyc;
  int timeouts;
  initial begin
    timeouts = 0;
    o_lines = '0;
    o_db = '0;
    o_db_oe_n = 1'b1;
    rst_cyc = 0;
  end
  // never arbitrates, so the initiator always wins
  always @(posedge i_clk_sys) begin
    rst_cyc <= i_rst ? rst_cyc + 1 : 0;
    if (i_reset || rst_cyc >= int'(scsiin_pkg::RST_PULSE_CYC)) begin
      o_lines <= '0;
      o_db_oe_n <= 1'b1;
    end else if (i_sel && i_db.data[TGT_ID] && !i_bsy && !o_lines.io) begin
      o_lines.bsy <= 1'b1;
    end
  end
  task automatic xfer(input logic [2:0] ph, input logic [7:0] d, input logic bad,
                      input int dly, output scsiin_pkg::scsiin_byte_t got);
    got = 'x;
    @(posedge i_clk_sys);
    {o_lines.msg, o_lines.cd, o_lines.io} <= ph;
    o_db <= {(~^d) ^ bad, d};
    o_db_oe_n <= !ph[scsiin_pkg::PH_IO_BIT];
    repeat (dly) @(posedge i_clk_sys);
    o_lines.req <= 1'b1;
    for (int n = 0; n < 200 && !i_ack; n++) @(posedge i_clk_sys);
    got = i_db;
    if (i_ack) begin
      @(posedge i_clk_sys);
      o_lines.req <= 1'b0;
      o_db_oe_n <= 1'b1;
      for (int n = 0; n < 200 && i_ack; n++) @(posedge i_clk_sys);
      if (i_ack) timeouts++;
    end else begin
      timeouts++;
    end
  endtask
  task automatic release_bus();
    @(posedge i_clk_sys);
    o_lines <= '0;
    o_db_oe_n <= 1'b1;
  endtask
endmodule

// >>> verification/tb_top.sv
// bench top: initiator controller against the target model
// assumes one 100 mhz clock; bus lines are wired-or and negated when released
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin bad_count++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
  logic i_clk_sys, i_reset, i_start, i_atn, i_bus_reset, i_release, o_tx_ready, o_rx_valid;
  logic o_connected, o_busy, o_sel_timeout, o_arb_lost, o_parity_err, o_db_oe_n, o_bsy;
  logic o_bsy_oe_n, o_sel, o_sel_oe_n, o_ack, o_atn, o_rst, perr_last, t_db_oe_n;
  logic [2:0]                 i_target_id, o_phase;
  logic [7:0]                 i_tx_data, o_rx_data, rx_last;
  logic [31:0]                seed;
  logic [2:0]                 phases [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
  scsiin_pkg::scsiin_bus_in_t i_bus, t_lines;
  scsiin_pkg::scsiin_byte_t   i_db, o_db, t_db, got;
  int                         bad_count, checked;
  int                         tx_ready_hits = 0, arb_lost_hits = 0;
  assign i_bus = {(!o_bsy_oe_n && o_bsy) || t_lines.bsy, !o_sel_oe_n && o_sel, t_lines.msg,
                  t_lines.cd, t_lines.io, t_lines.req, o_rst};
  assign i_db = (o_db_oe_n ? 9'h000 : o_db) | (t_db_oe_n ? 9'h000 : t_db);
  scsiin_ctrl #(.SEL_TMO(50), .OWN_ID(3'h7), .SKIP_ARB(1'b0)) DUT (.i_clk_sys, .i_reset,
    .i_start, .i_target_id, .i_atn, .i_bus_reset, .i_release, .i_tx_data, .o_tx_ready,
    .o_rx_data, .o_rx_valid, .o_phase, .o_connected, .o_busy, .o_sel_timeout, .o_arb_lost,
    .o_parity_err, .i_bus, .i_db, .o_db, .o_db_oe_n, .o_bsy, .o_bsy_oe_n, .o_sel,
    .o_sel_oe_n, .o_ack, .o_atn, .o_rst);
  scsiin_tgt_model #(.TGT_ID(3'h3)) tgt (.i_clk_sys, .i_reset, .i_bsy(i_bus.bsy),
    .i_sel(i_bus.sel), .i_ack(o_ack), .i_rst(o_rst), .i_db, .o_lines(t_lines), .o_db(t_db),
    .o_db_oe_n(t_db_oe_n));
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    if (o_tx_ready === 1'b1) tx_ready_hits++;
    if (o_arb_lost === 1'b1) arb_lost_hits++;
  end
  always @(posedge i_clk_sys) if (o_rx_valid === 1'b1) begin
    rx_last <= o_rx_data;
    perr_last <= o_parity_err;
  end
  // ==========================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic odd_par(input logic [7:0] d);
    return ~^d;
  endfunction
  task automatic tally_and_finish();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_for(input int w);
    int n;
    for (n = 0; n < 3000; n++) begin
      @(negedge i_clk_sys);
      if ((w == 0 && o_connected === 1'b1) || (w == 1 && o_sel_timeout === 1'b1) ||
          (w == 2 && o_busy === 1'b0 && o_connected === 1'b0)) break;
    end
    if (n == 3000) begin
      bad_count++;
      $display("CHECK FAILED wait %0d expected 1 seen 0", w);
      tally_and_finish();
    end
  endtask
  task automatic start(input logic [2:0] id);
    @(posedge i_clk_sys) i_target_id <= id;
    i_start <= 1'b1;
    @(posedge i_clk_sys) i_start <= 1'b0;
  endtask
  task automatic xfer_check(input logic [2:0] ph, input logic [7:0] d, input logic bad,
                            input int dly);
    int t0;
    @(posedge i_clk_sys) i_tx_data <= d;
    t0 = tx_ready_hits;
    tgt.xfer(ph, d, bad, dly, got);
    `CHK("phase", ph, o_phase)
    `CHK("tx ready", !ph[scsiin_pkg::PH_IO_BIT], tx_ready_hits > t0)
    if (ph[scsiin_pkg::PH_IO_BIT]) begin
      `CHK("rx data", d, rx_last)
      `CHK("parity flag", bad, perr_last)
    end else begin
      `CHK("tx data", d, got.data)
      `CHK("tx parity", odd_par(d), got.par)
    end
  endtask
  // ==========================================
  // main sequence
  initial begin
    int n;
    {i_reset, i_start, i_atn, i_bus_reset, i_release} = 5'h10;
    i_target_id = 3'h0;
    i_tx_data = 8'h00;
    {bad_count, checked} = '0;
    seed = 32'h2ecfce04;
    repeat (2) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    @(negedge i_clk_sys);
    `CHK("released pins", 3'b111, {o_bsy_oe_n, o_sel_oe_n, o_db_oe_n})
    start(3'h5);
    wait_for(1);
    wait_for(2);
    start(3'h3);
    wait_for(0);
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      xfer_check(phases[i % 6], seed[7:0], 1'b0, int'(seed[10:8]));
    end
    xfer_check(scsiin_pkg::PH_DATA_IN, 8'h00, 1'b1, 0);
    @(posedge i_clk_sys) i_atn <= 1'b1;
    repeat (4) @(negedge i_clk_sys);
    `CHK("attention", 1'b1, o_atn)
    @(posedge i_clk_sys) i_atn <= 1'b0;
    i_release <= 1'b1;
    tgt.release_bus();
    wait_for(2);
    @(posedge i_clk_sys) i_release <= 1'b0;
    @(negedge i_clk_sys);
    `CHK("bus free", 2'b00, {i_bus.bsy, i_bus.sel})
    @(posedge i_clk_sys) i_bus_reset <= 1'b1;
    @(posedge i_clk_sys) i_bus_reset <= 1'b0;
    for (n = 0; n < 50 && o_rst !== 1'b1; n++) @(negedge i_clk_sys);
    for (n = 0; n < 300 && o_rst === 1'b1; n++) @(negedge i_clk_sys);
    `CHK("reset width", 1'b1, n >= 80 && n < 300)
    wait_for(2);
    start(3'h3);
    wait_for(0);
    xfer_check(scsiin_pkg::PH_STATUS, seed[15:8], 1'b0, 2);
    `CHK("arb lost", 0, arb_lost_hits)
    `CHK("handshake timeouts", 0, tgt.timeouts)
    tally_and_finish();
  end
endmodule
